/* File: rtl/subtract_borrow_decrement_skip.v */
`timescale 1ns/1ps
`default_nettype none
`include "sbd_consts.vh"

// Execution datapath for subtract-with-borrow-to-memory and decrement-skip-if-null
module subtract_borrow_decrement_skip #(
	parameter ADDR_W = 8
) (
	// Clock, reset, enable
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	// Wishbone classic slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Pipeline side
	output reg busy_o,
	output reg skip_o,
	output reg dummy_o
);

	// Execution states
	localparam ST_IDLE = 2'b00;
	localparam ST_READ = 2'b01;
	localparam ST_EXEC = 2'b10;
	localparam ST_DUMMY = 2'b11;

	// Bus address decode, used for reads and writes
	function [2:0] reg_sel;
		input [7:0] adr;
		begin
			case (adr)
				`REG_CMD: reg_sel = `SEL_CMD;
				`REG_WORK: reg_sel = `SEL_WORK;
				`REG_STATUS: reg_sel = `SEL_STATUS;
				`REG_MADDR: reg_sel = `SEL_MADDR;
				`REG_MDATA: reg_sel = `SEL_MDATA;
				default: reg_sel = `SEL_NONE;
			endcase
		end
	endfunction

	// Architectural state
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg op_r;
	reg [ADDR_W-1:0] addr_r;
	reg [7:0] work_r;
	reg [5:0] flags_r;
	reg skip_armed_r;
	reg [ADDR_W-1:0] maddr_r;
	reg rd_wait_r;

	// Memory port
	reg mem_re;
	reg mem_we;
	reg [ADDR_W-1:0] mem_addr;
	reg [7:0] mem_wdata;
	wire [7:0] mem_q;

	// Bus request helpers
	wire bus_req;
	wire [2:0] bus_sel;
	wire bus_idle;
	wire bus_write_ok;
	wire bus_mrd_issue;
	wire start_cmd;

	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign bus_sel = reg_sel(wb_adr_i);
	assign bus_idle = (state_r == ST_IDLE);
	// Writes wait for an idle datapath so they never collide with a writeback
	assign bus_write_ok = bus_req & wb_we_i & bus_idle;
	assign bus_mrd_issue = bus_req & ~wb_we_i & bus_idle & (bus_sel == `SEL_MDATA) & ~rd_wait_r;
	// A command write while a skip is armed is squashed instead of executed
	assign start_cmd = bus_write_ok & (bus_sel == `SEL_CMD) & wb_sel_i[0] & ~skip_armed_r;

	// Subtract with borrow: acc + ~m + c, 8-bit operands
	wire [8:0] diff9;
	wire [4:0] half5;
	wire [7:0] sub_res;
	wire c_new;
	wire ac_new;
	wire z_new;
	wire ov_new;
	wire sc_new;
	wire cz_new;

	assign diff9 = {1'b0, work_r} + {1'b0, ~mem_q} + {8'h00, flags_r[`FLG_BORROW_INV]};
	assign half5 = {1'b0, work_r[3:0]} + {1'b0, ~mem_q[3:0]} + {4'h0, flags_r[`FLG_BORROW_INV]};
	assign sub_res = diff9[7:0];
	// Carry out of the inverted add is 1 exactly when no borrow was needed
	assign c_new = diff9[8];
	assign ac_new = half5[4];
	assign z_new = (sub_res == 8'h00);
	assign ov_new = (work_r[7] ^ mem_q[7]) & (work_r[7] ^ sub_res[7]);
	// Signed borrow: true signed sign of the difference
	assign sc_new = ov_new ^ sub_res[7];
	// Chained null holds only while this step and the previous one (the old null flag) were both zero
	assign cz_new = z_new & flags_r[`FLG_NULL];

	// Decrement wraps 00 to ff
	wire [7:0] dec_res;
	wire dec_null;
	assign dec_res = mem_q - 8'h01;
	assign dec_null = (dec_res == 8'h00);

	// Next state of the execution sequence
	always @* begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (start_cmd) begin
					state_nxt = ST_READ;
				end
			end
			ST_READ: begin
				state_nxt = ST_EXEC;
			end
			ST_EXEC: begin
				if (op_r == `OP_DEC_SKIP && dec_null) begin
					state_nxt = ST_DUMMY;
				end else begin
					state_nxt = ST_IDLE;
				end
			end
			ST_DUMMY: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Memory port steering: datapath first, bus only while idle
	always @* begin
		mem_re = 1'b0;
		mem_we = 1'b0;
		mem_addr = maddr_r;
		mem_wdata = wb_dat_i[7:0];
		case (state_r)
			ST_READ: begin
				mem_re = 1'b1;
				mem_addr = addr_r;
			end
			ST_EXEC: begin
				// Both instructions write back to the same location
				mem_we = 1'b1;
				mem_addr = addr_r;
				if (op_r == `OP_DEC_SKIP) begin
					mem_wdata = dec_res;
				end else begin
					mem_wdata = sub_res;
				end
			end
			ST_IDLE: begin
				mem_re = bus_mrd_issue;
				mem_we = bus_write_ok & (bus_sel == `SEL_MDATA) & wb_sel_i[0];
			end
			default: begin
				mem_re = 1'b0;
			end
		endcase
	end

	sbd_dmem #(
		.ADDR_W(ADDR_W),
		.DATA_W(8)
	) u_dmem (
		.clk_i(clk_i),
		.ce_i(ce_i),
		.re_i(mem_re),
		.we_i(mem_we),
		.addr_i(mem_addr),
		.wdata_i(mem_wdata),
		.rdata_o(mem_q)
	);

	// Execution sequence, flags and skip bookkeeping
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= ST_IDLE;
			op_r <= `OP_SUB_BORROW;
			addr_r <= {ADDR_W{1'b0}};
			flags_r <= `FLAGS_RST;
			skip_armed_r <= 1'b0;
			skip_o <= 1'b0;
			dummy_o <= 1'b0;
			busy_o <= 1'b0;
		end else if (ce_i) begin
			state_r <= state_nxt;
			busy_o <= (state_nxt != ST_IDLE);
			dummy_o <= (state_nxt == ST_DUMMY);
			skip_o <= 1'b0;
			if (start_cmd) begin
				op_r <= wb_dat_i[`CMD_OP_BIT];
				addr_r <= wb_dat_i[`CMD_ADDR_LSB +: ADDR_W];
			end
			// Squashed command consumes the armed skip
			if (bus_write_ok && bus_sel == `SEL_CMD && wb_sel_i[0] && skip_armed_r) begin
				skip_armed_r <= 1'b0;
			end
			// Software may rewrite the flags while idle
			if (bus_write_ok && bus_sel == `SEL_STATUS && wb_sel_i[0]) begin
				flags_r <= wb_dat_i[5:0];
			end
			if (state_r == ST_EXEC) begin
				if (op_r == `OP_SUB_BORROW) begin
					// Six flags updated together
					flags_r[`FLG_BORROW_INV] <= c_new;
					flags_r[`FLG_HALF_BORROW] <= ac_new;
					flags_r[`FLG_NULL] <= z_new;
					flags_r[`FLG_RANGE] <= ov_new;
					flags_r[`FLG_SIGNED_BORROW] <= sc_new;
					flags_r[`FLG_CHAINED_NULL] <= cz_new;
				end else if (dec_null) begin
					// Flags untouched by the decrement
					skip_armed_r <= 1'b1;
					skip_o <= 1'b1;
				end
			end
		end
	end

	// Software-visible working register and memory pointer
	always @(posedge clk_i) begin
		if (rst_i) begin
			work_r <= `WORK_RST;
			maddr_r <= `MADDR_RST;
		end else if (ce_i) begin
			if (bus_write_ok && bus_sel == `SEL_WORK && wb_sel_i[0]) begin
				work_r <= wb_dat_i[7:0];
			end
			if (bus_write_ok && bus_sel == `SEL_MADDR && wb_sel_i[0]) begin
				maddr_r <= wb_dat_i[ADDR_W-1:0];
			end
		end
	end

	// Read mux for immediate registers
	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h0000_0000;
		case (bus_sel)
			`SEL_CMD: begin
				rd_mux[`CMD_OP_BIT] = op_r;
				rd_mux[`CMD_ADDR_LSB +: ADDR_W] = addr_r;
			end
			`SEL_WORK: begin
				rd_mux[7:0] = work_r;
			end
			`SEL_STATUS: begin
				rd_mux[5:0] = flags_r;
				rd_mux[`STAT_BUSY] = ~bus_idle;
				rd_mux[`STAT_SKIP_ARMED] = skip_armed_r;
			end
			`SEL_MADDR: begin
				rd_mux[ADDR_W-1:0] = maddr_r;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// Bus answer: one wait cycle for memory reads, writes held off while busy
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
			rd_wait_r <= 1'b0;
		end else if (ce_i) begin
			wb_ack_o <= 1'b0;
			if (rd_wait_r) begin
				rd_wait_r <= 1'b0;
				wb_ack_o <= 1'b1;
				wb_dat_o <= {24'h00_0000, mem_q};
			end else if (bus_mrd_issue) begin
				rd_wait_r <= 1'b1;
			end else if (bus_req && !wb_we_i && bus_sel != `SEL_MDATA) begin
				// Unmapped reads answer zero
				wb_ack_o <= 1'b1;
				wb_dat_o <= rd_mux;
			end else if (bus_write_ok) begin
				// Unmapped writes are acked and dropped
				wb_ack_o <= 1'b1;
			end
		end
	end

endmodule // subtract_borrow_decrement_skip

`default_nettype wire

/* File: rtl/sbd_consts.vh */
// Behaviour
// - The subtract-with-borrow instruction computes working register minus memory operand minus the inverted borrow_inverse_bit.
// - The subtract-with-borrow result goes back into the addressed data memory word, not into the working register.
// - After subtract-with-borrow, borrow_inverse_bit is 0 for a negative difference and 1 for a zero or positive one.
// - Subtract-with-borrow updates signed_range_exceeded_bit, null_result_bit, half_borrow_bit, borrow_inverse_bit, signed_borrow_bit and chained_null_bit.
// - Decrement_skip_if_null subtracts 1 from the addressed memory word, writes it back and leaves all flags alone.
// - When the decremented value is 0 the following instruction is skipped and not executed.
// - A skip inserts a dummy cycle while the next instruction is fetched, so the skipping instruction takes two cycles (here 3 clocks: read, execute, dummy).
// - When the decremented value is not 0 execution continues with the next instruction and no skip is taken.
`ifndef SBD_CONSTS_VH
`define SBD_CONSTS_VH

// Register byte offsets on the bus
`define REG_CMD 8'h00
`define REG_WORK 8'h04
`define REG_STATUS 8'h08
`define REG_MADDR 8'h0c
`define REG_MDATA 8'h10

// Register selector codes
`define SEL_CMD 3'h0
`define SEL_WORK 3'h1
`define SEL_STATUS 3'h2
`define SEL_MADDR 3'h3
`define SEL_MDATA 3'h4
`define SEL_NONE 3'h7

// Command register fields
`define CMD_OP_BIT 0
`define CMD_ADDR_LSB 8
`define OP_SUB_BORROW 1'b0
`define OP_DEC_SKIP 1'b1

// Status flag positions
`define FLG_BORROW_INV 0
`define FLG_HALF_BORROW 1
`define FLG_NULL 2
`define FLG_RANGE 3
`define FLG_SIGNED_BORROW 4
`define FLG_CHAINED_NULL 5
`define STAT_BUSY 8
`define STAT_SKIP_ARMED 9

// Reset values
`define FLAGS_RST 6'h00
`define WORK_RST 8'h00
`define MADDR_RST 8'h00

// Timing: cycles spent in the dummy slot after a skip
`define DUMMY_CYCLES 1

`endif

/* File: rtl/sbd_dmem.v */
`timescale 1ns/1ps
`default_nettype none

// Single port data memory, read data registered
module sbd_dmem #(
	parameter ADDR_W = 8,
	parameter DATA_W = 8
) (
	// Clock
	input wire clk_i,
	input wire ce_i,
	// Access port
	input wire re_i,
	input wire we_i,
	input wire [ADDR_W-1:0] addr_i,
	input wire [DATA_W-1:0] wdata_i,
	output reg [DATA_W-1:0] rdata_o
);

	reg [DATA_W-1:0] mem_r [0:(1<<ADDR_W)-1];

	// Memory content is not reset; software seeds it before use
	always @(posedge clk_i) begin
		if (ce_i) begin
			if (we_i) begin
				mem_r[addr_i] <= wdata_i;
			end
			if (re_i) begin
				rdata_o <= mem_r[addr_i];
			end
		end
	end

endmodule // sbd_dmem

`default_nettype wire

/* File: testbench/sbd_checker_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module sbd_checker (
	// Clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Bus handshake
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// Pipeline side
	input wire logic busy_o,
	input wire logic skip_o,
	input wire logic dummy_o
);
	// A frozen enable stretches every pulse, so checks pause with it
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i || !ce_i);

	a_skip_has_dummy: assert property (skip_o |-> dummy_o && busy_o)
		else $error("skip without dummy slot");
	a_dummy_one_slot: assert property (dummy_o |=> !dummy_o && !busy_o)
		else $error("dummy slot longer than one cycle");
	a_skip_single: assert property (skip_o |=> !skip_o)
		else $error("skip pulse too long");
	a_dummy_needs_skip: assert property (dummy_o |-> skip_o)
		else $error("dummy slot without skip");
	a_exec_length: assert property ($rose(busy_o) |=> busy_o ##1 (!busy_o || skip_o))
		else $error("instruction length wrong");
	a_skip_after_exec: assert property (skip_o |-> $past(busy_o) && $past(busy_o, 2))
		else $error("skip not preceded by execution");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	// Enable low freezes every output; only reset may override it
	a_freeze_holds: assert property (disable iff (rst_i)
		!ce_i |=> $stable(busy_o) && $stable(skip_o) && $stable(dummy_o) && $stable(wb_ack_o))
		else $error("outputs moved while enable low");
	// Reset itself is the antecedent, so this one must not be disabled by it
	a_reset_quiet: assert property (disable iff (1'h0)
		$fell(rst_i) |-> !busy_o && !skip_o && !dummy_o && !wb_ack_o)
		else $error("outputs active after reset");
endmodule // sbd_checker

bind subtract_borrow_decrement_skip sbd_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.busy_o(busy_o), .skip_o(skip_o), .dummy_o(dummy_o));
`default_nettype wire

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbd_consts.vh"
module tb_top;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic cyc = 1'h0;
	logic we = 1'h0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic ce = 1'h1;
	logic [3:0] sel = 4'hf;
	logic [3:0] lanes = 4'hf;
	logic [31:0] rdat;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, busy_o, skip_o, dummy_o;
	int bad_count = 0;
	int compares = 0;
	int skips = 0;

	// 25 MHz clock
	always #20 clk_i = ~clk_i;

	// Strobe follows cycle; enable and byte lanes are driven so their effects can be judged
	subtract_borrow_decrement_skip u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.busy_o(busy_o), .skip_o(skip_o), .dummy_o(dummy_o));

	// Skip pulses are counted so a scenario can judge them afterwards
	always @(posedge clk_i) begin
		if (skip_o === 1'h1) begin
			skips <= skips + 1;
		end
	end

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= lanes;
		do @(posedge clk_i); while (wb_ack_o !== 1'h1);
		rdat = wb_dat_o;
		cyc <= 1'h0;
		@(posedge clk_i);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %0t got %h want %h", $time, got, exp);
		end
	endtask

	// Expectations from true unsigned and signed differences; zp presets the old null flag
	task automatic sub_case(input logic [7:0] a, input logic [7:0] m, input logic c, input logic zp);
		logic [8:0] d;
		logic [4:0] h;
		int sd;
		logic z;
		d = {1'h0, a} - {1'h0, m} - {8'h0, ~c};
		h = {1'h0, a[3:0]} - {1'h0, m[3:0]} - {4'h0, ~c};
		sd = $signed(a) - $signed(m) - (c ? 0 : 1);
		z = d[7:0] == 8'h00;
		bus(1'h1, `REG_STATUS, {29'h0, zp, 1'h0, c});
		bus(1'h1, `REG_WORK, {24'h0, a});
		bus(1'h1, `REG_MADDR, 32'h21);
		bus(1'h1, `REG_MDATA, {24'h0, m});
		bus(1'h1, `REG_CMD, 32'h2100);
		bus(1'h0, `REG_MDATA, 32'h0);
		chk(rdat, {24'h0, d[7:0]});
		bus(1'h0, `REG_WORK, 32'h0);
		chk(rdat, {24'h0, a});
		bus(1'h0, `REG_STATUS, 32'h0);
		chk({26'h0, rdat[5:0]}, {26'h0, z & zp, sd < 0, sd < -128 || sd > 127, z, ~h[4], ~d[8]});
	endtask

	// Registers read back their reset values and no skip is armed
	task automatic reset_case;
		bus(1'h0, `REG_STATUS, 32'h0);
		chk(rdat, 32'h0);
		bus(1'h0, `REG_WORK, 32'h0);
		chk(rdat, 32'h0);
		bus(1'h0, `REG_MADDR, 32'h0);
		chk(rdat, 32'h0);
	endtask

	// Enable held low in the execute slot: the writeback waits and lands once
	task automatic freeze_case;
		bus(1'h1, `REG_MADDR, 32'h44);
		bus(1'h1, `REG_MDATA, 32'h09);
		cyc <= 1'h1;
		we <= 1'h1;
		adr <= `REG_CMD;
		dat <= 32'h4401;
		do @(posedge clk_i); while (wb_ack_o !== 1'h1);
		cyc <= 1'h0;
		ce <= 1'h0;
		repeat (4) begin
			@(posedge clk_i);
			chk({31'h0, busy_o}, 32'h1);
		end
		ce <= 1'h1;
		bus(1'h0, `REG_MDATA, 32'h0);
		chk(rdat, 32'h08);
	endtask

	task automatic dec_case(input logic [7:0] m);
		logic [7:0] e;
		int s;
		e = m - 8'h01;
		s = skips;
		bus(1'h1, `REG_STATUS, 32'h15);
		bus(1'h1, `REG_MADDR, 32'h33);
		bus(1'h1, `REG_MDATA, {24'h0, m});
		bus(1'h1, `REG_CMD, 32'h3301);
		bus(1'h0, `REG_MDATA, 32'h0);
		chk(rdat, {24'h0, e});
		chk(skips - s, {31'h0, e == 8'h00});
		bus(1'h0, `REG_STATUS, 32'h0);
		chk({26'h0, rdat[5:0]}, 32'h15);
		chk({31'h0, rdat[`STAT_SKIP_ARMED]}, {31'h0, e == 8'h00});
	endtask

	task wrap_up;
		$display("bad_count %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		reset_case;
		bus(1'h0, 8'h20, 32'h0);
		chk(rdat, 32'h0);
		sub_case(8'h10, 8'h20, 1'h1, 1'h1);
		sub_case(8'h50, 8'h50, 1'h1, 1'h1);
		sub_case(8'h50, 8'h50, 1'h1, 1'h0);
		sub_case(8'h80, 8'h01, 1'h1, 1'h1);
		sub_case(8'h7f, 8'hff, 1'h1, 1'h1);
		sub_case(8'h12, 8'h03, 1'h1, 1'h1);
		sub_case(8'h05, 8'h04, 1'h0, 1'h1);
		dec_case(8'h01);
		// The squashed instruction must leave the word at zero
		bus(1'h1, `REG_CMD, 32'h3301);
		bus(1'h0, `REG_MDATA, 32'h0);
		chk(rdat, 32'h0);
		dec_case(8'h00);
		dec_case(8'h05);
		freeze_case;
		// A command with lane 0 off is acked but never runs
		lanes = 4'he;
		bus(1'h1, `REG_CMD, 32'h4401);
		lanes = 4'hf;
		bus(1'h0, `REG_MDATA, 32'h0);
		chk(rdat, 32'h08);
		// Skip left armed, then a second reset must clear it
		dec_case(8'h01);
		rst_i <= 1'h1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		reset_case;
		wrap_up;
	end

	// Watchdog: the whole run needs well under a thousand cycles
	initial begin
		#50us;
		bad_count++;
		wrap_up;
	end
endmodule // tb_top
`default_nettype wire
